// [rtl/ddr4f_host.sv]
`timescale 1ns/10ps
module ddr4f_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // User command port
    input wire logic cmdValid,
    input wire ddr4f_pkg::ddr4f_cmd_s cmd,
    output logic cmdReady,
    output logic cmdDone,
    output logic cmdRefused,
    // Device control fields and status
    output ddr4f_pkg::ddr4f_ctl_s devCtl,
    input wire ddr4f_pkg::ddr4f_stat_s devStat
);
    typedef struct packed {
        ddr4f_pkg::ddr4f_state_e st;
        ddr4f_pkg::ddr4f_state_e after;
        ddr4f_pkg::ddr4f_inv_s newInv;
        logic restoreWr;
        logic [ddr4f_pkg::WAIT_W-1:0] waitCnt;
        logic [ddr4f_pkg::MRVAL_W-1:0] invMrBase;
        ddr4f_pkg::ddr4f_cmd_s saved;
        ddr4f_pkg::ddr4f_ctl_s ctl;
        logic ready;
        logic done;
        logic refused;
    } ddr4f_host_s;

    ddr4f_host_s s_q, s_d;

    // MR5 image with the three enables written in
    function automatic logic [ddr4f_pkg::MRVAL_W-1:0] invImage(
        input logic [ddr4f_pkg::MRVAL_W-1:0] base, input ddr4f_pkg::ddr4f_inv_s inv);
        logic [ddr4f_pkg::MRVAL_W-1:0] v;
        v = base;
        v[ddr4f_pkg::MR5_RD_INV_BIT] = inv.rd;
        v[ddr4f_pkg::MR5_WR_INV_BIT] = inv.wr;
        v[ddr4f_pkg::MR5_DM_BIT] = inv.mask;
        return v;
    endfunction

    // ========================================================
    // Sequencer
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.refused = 1'b0;
        s_d.ctl.modeRegWriteTrigger = 1'b0;
        s_d.ctl.alertCountClear = 1'b0;
        s_d.ctl.alertIrqClear = 1'b0;
        case (s_q.st)
            ddr4f_pkg::S_IDLE: begin
                if (cmdValid && s_q.ready) begin
                    s_d.saved = cmd;
                    s_d.ready = 1'b0;
                    case (cmd.op)
                        ddr4f_pkg::OP_SET_INV: begin
                            // Inversion on x4 parts, or write inversion with mask, is refused
                            if ((cmd.x4Memory && (cmd.inv.rd || cmd.inv.wr))
                                    || (cmd.inv.wr && cmd.inv.mask)) begin
                                s_d.refused = 1'b1;
                                s_d.ready = 1'b1;
                            end else begin
                                s_d.newInv = cmd.inv;
                                s_d.invMrBase = cmd.modeRegValue;
                                s_d.after = ddr4f_pkg::S_FINISH;
                                s_d.st = ddr4f_pkg::S_HALT;
                            end
                        end
                        ddr4f_pkg::OP_PER_DEV: begin
                            if (s_q.ctl.inv.wr) begin
                                // Write inversion must be off around the sequence, restored afterwards
                                s_d.newInv = s_q.ctl.inv;
                                s_d.newInv.wr = 1'b0;
                                s_d.restoreWr = 1'b1;
                                s_d.after = ddr4f_pkg::S_PLOAD;
                                s_d.st = ddr4f_pkg::S_HALT;
                            end else begin
                                s_d.st = ddr4f_pkg::S_PLOAD;
                            end
                        end
                        ddr4f_pkg::OP_CLR_ALERT: begin
                            s_d.ctl.alertCountClear = 1'b1;
                            s_d.ctl.alertIrqClear = 1'b1;
                            s_d.done = 1'b1;
                            s_d.ready = 1'b1;
                        end
                        default: begin
                            // Error flag cleared by an ordinary mode-register write
                            s_d.invMrBase = cmd.modeRegValue;
                            s_d.invMrBase[ddr4f_pkg::MR5_CRC_ERR_BIT] = 1'b0;
                            s_d.ctl.modeRegNumber = ddr4f_pkg::MR_INV_NUM;
                            s_d.ctl.modeRegAccessType = ddr4f_pkg::MODEREG_TYPE_WRITE;
                            s_d.ctl.modeRegValue = invImage(s_d.invMrBase, s_q.ctl.inv);
                            s_d.ctl.perDeviceEnable = 1'b0;
                            s_d.after = ddr4f_pkg::S_FINISH;
                            s_d.st = ddr4f_pkg::S_MRW;
                        end
                    endcase
                end
            end
            ddr4f_pkg::S_HALT: begin
                s_d.ctl.dqHalt = 1'b1;
                s_d.st = ddr4f_pkg::S_DRAIN;
            end
            ddr4f_pkg::S_DRAIN: begin
                if (devStat.writePipeEmpty && devStat.readPipeEmpty) begin
                    s_d.st = ddr4f_pkg::S_SETEN;
                end
            end
            ddr4f_pkg::S_SETEN: begin
                s_d.ctl.inv = s_q.newInv;
                s_d.ctl.inversionPlacement = s_q.saved.placeInPhy;
                s_d.ctl.crcEnable = s_q.saved.crcEnable;
                s_d.ctl.checksumIncludeMask = s_q.saved.checksumIncludeMask;
                s_d.ctl.parityEnable = s_q.saved.parityEnable;
                // Read inversion costs extra CAS latency; the read timings follow it
                s_d.ctl.casLatency = s_q.newInv.rd ? s_q.saved.baseCasLatency + s_q.saved.readInvLatencyAdd
                                                   : s_q.saved.baseCasLatency;
                if (s_q.saved.crcEnable && s_q.newInv.mask) begin
                    s_d.ctl.writeTerminationHold = ddr4f_pkg::HOLD_BASE + s_q.saved.writePreamble
                                                   + ddr4f_pkg::HOLD_EXTRA;
                end
                s_d.ctl.modeRegNumber = ddr4f_pkg::MR_INV_NUM;
                s_d.ctl.modeRegAccessType = ddr4f_pkg::MODEREG_TYPE_WRITE;
                s_d.ctl.modeRegValue = invImage(s_q.invMrBase, s_q.newInv);
                s_d.ctl.perDeviceEnable = 1'b0;
                s_d.st = ddr4f_pkg::S_MRW;
            end
            ddr4f_pkg::S_MRW: begin
                s_d.ctl.modeRegWriteTrigger = 1'b1;
                s_d.waitCnt = ddr4f_pkg::WAIT_W'(ddr4f_pkg::MR_WAIT_CYC);
                s_d.st = ddr4f_pkg::S_MRWAIT;
            end
            ddr4f_pkg::S_MRWAIT: begin
                if (s_q.waitCnt != '0) begin
                    s_d.waitCnt = s_q.waitCnt - 1'b1;
                end else if (s_q.ctl.dqHalt) begin
                    // Retune only once the new latency is in the mode register
                    s_d.ctl.readDataEnableDelay = s_q.ctl.casLatency - ddr4f_pkg::RDEN_OFFSET;
                    s_d.ctl.readLatency = s_q.ctl.casLatency;
                    s_d.ctl.readToWrite = s_q.ctl.casLatency + ddr4f_pkg::RD2WR_EXTRA;
                    s_d.st = ddr4f_pkg::S_UNHALT;
                end else begin
                    s_d.st = s_q.after;
                end
            end
            ddr4f_pkg::S_UNHALT: begin
                s_d.ctl.dqHalt = 1'b0;
                s_d.st = s_q.after;
            end
            ddr4f_pkg::S_PLOAD: begin
                s_d.ctl.modeRegTargetRank = s_q.saved.rank;
                s_d.ctl.modeRegDeviceSelect = s_q.saved.devSel;
                s_d.ctl.modeRegAccessType = s_q.saved.modeRegType;
                s_d.ctl.modeRegNumber = s_q.saved.modeRegNumber;
                s_d.ctl.modeRegValue = s_q.saved.modeRegValue;
                s_d.st = ddr4f_pkg::S_PEN;
            end
            ddr4f_pkg::S_PEN: begin
                s_d.ctl.perDeviceEnable = 1'b1;
                s_d.st = ddr4f_pkg::S_PTRIG;
            end
            ddr4f_pkg::S_PTRIG: begin
                s_d.ctl.modeRegWriteTrigger = 1'b1;
                s_d.st = ddr4f_pkg::S_PWAIT;
            end
            ddr4f_pkg::S_PWAIT: begin
                if (devStat.perDeviceDone) begin
                    s_d.ctl.perDeviceEnable = 1'b0;
                    s_d.st = ddr4f_pkg::S_PCLR;
                end
            end
            ddr4f_pkg::S_PCLR: begin
                // Wait for the device to drop done before anything else
                if (!devStat.perDeviceDone) begin
                    if (s_q.restoreWr) begin
                        s_d.restoreWr = 1'b0;
                        s_d.newInv = s_q.ctl.inv;
                        s_d.newInv.wr = 1'b1;
                        s_d.after = ddr4f_pkg::S_FINISH;
                        s_d.st = ddr4f_pkg::S_HALT;
                    end else begin
                        s_d.st = ddr4f_pkg::S_FINISH;
                    end
                end
            end
            ddr4f_pkg::S_FINISH: begin
                s_d.done = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = ddr4f_pkg::S_IDLE;
            end
            default: begin
                s_d.st = ddr4f_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= ddr4f_pkg::S_IDLE;
            s_q.after <= ddr4f_pkg::S_FINISH;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmdReady = s_q.ready;
    assign cmdDone = s_q.done;
    assign cmdRefused = s_q.refused;
    assign devCtl = s_q.ctl;
endmodule

// [include/ddr4f_pkg.sv]
package ddr4f_pkg;
    localparam int RANK_W = 2;
    localparam int DEVSEL_W = 9;
    localparam int MRNUM_W = 3;
    localparam int MRVAL_W = 18;
    localparam int LAT_W = 7;
    localparam int HOLD_W = 4;
    localparam int WAIT_W = 8;
    // Mode register holding inversion, mask and CRC error flag
    localparam logic [MRNUM_W-1:0] MR_INV_NUM = 3'h5;
    localparam int MR5_CRC_ERR_BIT = 3;
    localparam int MR5_DM_BIT = 10;
    localparam int MR5_WR_INV_BIT = 11;
    localparam int MR5_RD_INV_BIT = 12;
    localparam logic MODEREG_TYPE_WRITE = 1'b0;
    // Termination hold with CRC and mask: 5 + preamble + 1
    localparam logic [HOLD_W-1:0] HOLD_BASE = 4'h5;
    localparam logic [HOLD_W-1:0] HOLD_EXTRA = 4'h1;
    // Read timings derived from CAS latency
    localparam logic [LAT_W-1:0] RDEN_OFFSET = 7'h02;
    localparam logic [LAT_W-1:0] RD2WR_EXTRA = 7'h04;
    // Settle time after a mode-register write trigger
    localparam int MR_WAIT_NS = 50;
    localparam int CLK_NS = 5;
    localparam int MR_WAIT_CYC = (MR_WAIT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {OP_SET_INV, OP_PER_DEV, OP_CLR_ALERT, OP_CLR_CRC} ddr4f_op_e;

    typedef enum logic [3:0] {
        S_IDLE, S_HALT, S_DRAIN, S_SETEN, S_MRW, S_MRWAIT, S_UNHALT,
        S_PLOAD, S_PEN, S_PTRIG, S_PWAIT, S_PCLR, S_FINISH
    } ddr4f_state_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic mask;
    } ddr4f_inv_s;

    typedef struct packed {
        ddr4f_op_e op;
        ddr4f_inv_s inv;
        logic x4Memory;
        logic placeInPhy;
        logic crcEnable;
        logic checksumIncludeMask;
        logic parityEnable;
        logic [HOLD_W-1:0] writePreamble;
        logic [LAT_W-1:0] baseCasLatency;
        logic [LAT_W-1:0] readInvLatencyAdd;
        logic [RANK_W-1:0] rank;
        logic [DEVSEL_W-1:0] devSel;
        logic modeRegType;
        logic [MRNUM_W-1:0] modeRegNumber;
        logic [MRVAL_W-1:0] modeRegValue;
    } ddr4f_cmd_s;

    typedef struct packed {
        logic dqHalt;
        ddr4f_inv_s inv;
        logic inversionPlacement;
        logic crcEnable;
        logic checksumIncludeMask;
        logic parityEnable;
        logic [HOLD_W-1:0] writeTerminationHold;
        logic [LAT_W-1:0] casLatency;
        logic [LAT_W-1:0] readDataEnableDelay;
        logic [LAT_W-1:0] readLatency;
        logic [LAT_W-1:0] readToWrite;
        logic [RANK_W-1:0] modeRegTargetRank;
        logic [DEVSEL_W-1:0] modeRegDeviceSelect;
        logic modeRegAccessType;
        logic [MRNUM_W-1:0] modeRegNumber;
        logic [MRVAL_W-1:0] modeRegValue;
        logic perDeviceEnable;
        logic modeRegWriteTrigger;
        logic alertCountClear;
        logic alertIrqClear;
    } ddr4f_ctl_s;

    typedef struct packed {
        logic writePipeEmpty;
        logic readPipeEmpty;
        logic perDeviceDone;
    } ddr4f_stat_s;
endpackage

// [test/ddr4f_dev_model.sv]
`timescale 1ns/10ps
module ddr4f_dev_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Slow drain select
    input wire logic slowDrain,
    // Control fields and status
    input wire ddr4f_pkg::ddr4f_ctl_s devCtl,
    output ddr4f_pkg::ddr4f_stat_s devStat
);
    // ==========
    // Pipe drain and per-device sequence
    logic [3:0] drainCnt_q;
    logic [3:0] seqCnt_q;
    logic done_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drainCnt_q <= 4'h0;
            seqCnt_q <= 4'h0;
            done_q <= 1'h0;
        end else begin
            drainCnt_q <= (!devCtl.dqHalt) ? 4'h0 : ((drainCnt_q == 4'hF) ? drainCnt_q : drainCnt_q + 4'h1);
            if (!devCtl.perDeviceEnable) begin
                done_q <= 1'h0;
                seqCnt_q <= 4'h0;
            end else if (devCtl.modeRegWriteTrigger) begin
                seqCnt_q <= 4'h1;
            end else if (seqCnt_q != 4'h0 && seqCnt_q < 4'h9) begin
                seqCnt_q <= seqCnt_q + 4'h1;
            end else if (seqCnt_q == 4'h9) begin
                done_q <= 1'h1;
            end
        end
    end
    // Traffic keeps pipes busy unless halted, so empty is never shown early
    assign devStat.writePipeEmpty = devCtl.dqHalt && drainCnt_q >= (slowDrain ? 4'hC : 4'h1);
    assign devStat.readPipeEmpty = devCtl.dqHalt && drainCnt_q >= (slowDrain ? 4'h9 : 4'h0);
    assign devStat.perDeviceDone = done_q;
endmodule

// [test/ddr4f_host_sva.sv]
`timescale 1ns/10ps
module ddr4f_host_sva (
    // Host ports
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire ddr4f_pkg::ddr4f_cmd_s cmd,
    input wire logic cmdReady,
    input wire logic cmdDone,
    input wire logic cmdRefused,
    input wire ddr4f_pkg::ddr4f_ctl_s devCtl,
    input wire ddr4f_pkg::ddr4f_stat_s devStat
);
    // ==========
    // Helpers
    logic take;
    logic setInv;
    logic [ddr4f_pkg::HOLD_W-1:0] preamble_q;
    assign take = cmdValid && cmdReady;
    assign setInv = take && cmd.op == ddr4f_pkg::OP_SET_INV;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            preamble_q <= '0;
        end else if (setInv) begin
            preamble_q <= cmd.writePreamble;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========
    // Properties
    x4_refuse_a: assert property (setInv && cmd.x4Memory && (cmd.inv.rd || cmd.inv.wr) |-> ##[1:2] cmdRefused)
        else $error("x4 inversion not refused");
    dm_refuse_a: assert property (setInv && cmd.inv.wr && cmd.inv.mask |-> ##[1:2] cmdRefused)
        else $error("inversion with mask not refused");
    wr_mask_a: assert property (!(devCtl.inv.wr && devCtl.inv.mask))
        else $error("inversion and mask together");
    halt_first_a: assert property ($changed(devCtl.inv) |-> devCtl.dqHalt
        && $past(devStat.writePipeEmpty && devStat.readPipeEmpty)) else $error("enables changed unhalted");
    mr_mirror_a: assert property (devCtl.modeRegWriteTrigger && devCtl.dqHalt && !devCtl.perDeviceEnable |->
        devCtl.modeRegValue[ddr4f_pkg::MR5_RD_INV_BIT] == devCtl.inv.rd
        && devCtl.modeRegValue[ddr4f_pkg::MR5_WR_INV_BIT] == devCtl.inv.wr
        && devCtl.modeRegValue[ddr4f_pkg::MR5_DM_BIT] == devCtl.inv.mask) else $error("mode value mismatch");
    cl_timing_a: assert property ($fell(devCtl.dqHalt) |-> devCtl.readLatency == devCtl.casLatency
        && devCtl.readToWrite == devCtl.casLatency + ddr4f_pkg::RD2WR_EXTRA
        && devCtl.readDataEnableDelay == devCtl.casLatency - ddr4f_pkg::RDEN_OFFSET) else $error("read timings");
    device_order_a: assert property (devCtl.modeRegWriteTrigger && devCtl.perDeviceEnable |->
        $past(devCtl.perDeviceEnable) && $stable(devCtl.modeRegTargetRank)) else $error("trigger before enable");
    device_wrinv_a: assert property (devCtl.perDeviceEnable |-> !devCtl.inv.wr)
        else $error("write inversion during per-device");
    done_clear_a: assert property ($fell(devCtl.perDeviceEnable) |-> $past(devStat.perDeviceDone))
        else $error("enable cleared early");
    crc_clear_a: assert property (take && cmd.op == ddr4f_pkg::OP_CLR_CRC |-> ##[1:4] devCtl.modeRegWriteTrigger
        && devCtl.modeRegNumber == ddr4f_pkg::MR_INV_NUM
        && !devCtl.modeRegValue[ddr4f_pkg::MR5_CRC_ERR_BIT]) else $error("flag clear");
    alert_clr_a: assert property (take && cmd.op == ddr4f_pkg::OP_CLR_ALERT |-> ##[1:2]
        devCtl.alertCountClear && devCtl.alertIrqClear && cmdDone) else $error("alert clear");
    hold_value_a: assert property ($fell(devCtl.dqHalt) && devCtl.crcEnable && devCtl.inv.mask |->
        devCtl.writeTerminationHold == preamble_q + ddr4f_pkg::HOLD_BASE + ddr4f_pkg::HOLD_EXTRA)
        else $error("hold");
endmodule
bind ddr4f_host ddr4f_host_sva u_sva (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdRefused(cmdRefused), .devCtl(devCtl), .devStat(devStat));

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic cmdValid = 1'h0;
    logic slowDrain = 1'h0;
    ddr4f_pkg::ddr4f_cmd_s cmd = '0;
    ddr4f_pkg::ddr4f_cmd_s c;
    logic cmdReady;
    logic cmdDone;
    logic cmdRefused;
    logic gotRefused;
    logic refExp;
    logic [7:0] lfsr = 8'h47;
    ddr4f_pkg::ddr4f_ctl_s devCtl;
    ddr4f_pkg::ddr4f_stat_s devStat;
    int fail_count = 0;
    int comparisons = 0;
    int holdExp = 0;
    int lat;
    int cl;
    always #2.5 core_clk = ~core_clk;
    ddr4f_host u_dut (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
        .cmdDone(cmdDone), .cmdRefused(cmdRefused), .devCtl(devCtl), .devStat(devStat));
    ddr4f_dev_model u_dev (.core_clk(core_clk), .rst(rst), .slowDrain(slowDrain), .devCtl(devCtl),
        .devStat(devStat));
    // ==========
    // Shared tasks
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Called at a falling edge; one spare cycle keeps strobes from toggling twice in a step
    task automatic send(input ddr4f_pkg::ddr4f_cmd_s cv);
        @(negedge core_clk);
        while (cmdReady !== 1'h1) begin
            @(negedge core_clk);
        end
        cmdValid = 1'h1;
        cmd = cv;
        @(negedge core_clk);
        cmdValid = 1'h0;
        lat = 1;
        while (cmdDone !== 1'h1 && cmdRefused !== 1'h1 && lat < 4000) begin
            @(negedge core_clk);
            lat++;
        end
        gotRefused = cmdRefused;
        check(lat < 4000, 1);
    endtask
    // ==========
    // Scenarios
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'h0;
        for (int k = 0; k < 32; k++) begin
            lfsr = lfsr_next(lfsr);
            c = '0;
            c.op = ddr4f_pkg::OP_SET_INV;
            {c.x4Memory, c.inv} = k[3:0];
            {c.placeInPhy, c.crcEnable, c.parityEnable, c.checksumIncludeMask} = lfsr[3:0];
            c.writePreamble = lfsr[7:4];
            c.baseCasLatency = 7'h0A + lfsr[4:0];
            c.readInvLatencyAdd = {5'h00, lfsr[6:5]};
            slowDrain = k[4];
            send(c);
            refExp = (c.x4Memory && (c.inv.rd || c.inv.wr)) || (c.inv.wr && c.inv.mask);
            check(gotRefused, refExp);
            if (!refExp) begin
                if (c.crcEnable && c.inv.mask) begin
                    holdExp = (c.writePreamble + 6) % 16;
                end
                cl = c.baseCasLatency + (c.inv.rd ? c.readInvLatencyAdd : 0);
                check(devCtl.inv, c.inv);
                check(devCtl.inversionPlacement, c.placeInPhy);
                check(devCtl.crcEnable, c.crcEnable);
                check(devCtl.checksumIncludeMask, c.checksumIncludeMask);
                check(devCtl.parityEnable, c.parityEnable);
                check(devCtl.inversionPlacement == 1'h0, !c.placeInPhy);
                check(devCtl.casLatency, cl);
                check(devCtl.readLatency, cl);
                check(devCtl.readToWrite, cl + 4);
                check(devCtl.readDataEnableDelay, cl - 2);
                check(devCtl.writeTerminationHold, holdExp);
                check(devCtl.dqHalt, 0);
            end
        end
        for (int j = 0; j < 2; j++) begin
            c = '0;
            c.op = ddr4f_pkg::OP_SET_INV;
            c.inv.wr = j[0];
            c.baseCasLatency = 7'h10;
            send(c);
            lfsr = lfsr_next(lfsr);
            c.op = ddr4f_pkg::OP_PER_DEV;
            c.rank = lfsr[1:0];
            c.devSel = {lfsr, 1'h1};
            c.modeRegValue = {10'h000, lfsr};
            send(c);
            check(devCtl.inv.wr, j);
            check(devCtl.perDeviceEnable, 0);
            check(devCtl.modeRegTargetRank, c.rank);
            check(devCtl.modeRegDeviceSelect, c.devSel);
            if (j == 0) begin
                check(devCtl.modeRegValue, c.modeRegValue);
            end
        end
        c = '0;
        c.op = ddr4f_pkg::OP_CLR_ALERT;
        send(c);
        check(lat <= 3, 1);
        c.op = ddr4f_pkg::OP_CLR_CRC;
        c.modeRegValue = 18'h3FFFF;
        send(c);
        check(devCtl.modeRegValue[3], 0);
        check(devCtl.modeRegNumber, 5);
        check(devCtl.modeRegValue[0], 1);
        check(devCtl.modeRegValue[ddr4f_pkg::MR5_WR_INV_BIT], 1);
        check(lat > ddr4f_pkg::MR_WAIT_CYC, 1);
        give_verdict();
    end
    initial begin
        // Scenarios need a few hundred cycles even with slow drains
        repeat (20000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end
endmodule
